// ==== hdl/exec_pkg.sv ====
/*
  shared constants and carrier types for the branch and increment execution block.
  assumes a 14-bit instruction word, 13-bit program counter, 128-entry data file.
*/
package exec_pkg;
  localparam int PC_W     = 13;
  localparam int INSN_W   = 14;
  localparam int ADDR_W   = 7;
  localparam int DATA_W   = 8;
  localparam int LIT_W    = 11;
  // instruction field positions
  localparam int TOP_HI   = 13;
  localparam int TOP_LO   = 12;
  localparam int OP_HI    = 13;
  localparam int OP_LO    = 8;
  localparam int DEST_BIT = 7;
  localparam int PAGE_HI  = 4;
  localparam int PAGE_LO  = 3;
  // opcodes
  localparam logic [1:0] BRANCH_TOP  = 2'h2;
  localparam logic [5:0] INC_OPC     = 6'h0A;
  localparam logic [5:0] INC_SKIP_OPC = 6'h0F;
  // reset values
  localparam logic [PC_W-1:0]   PC_RESET   = 13'h0000;
  localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;
  localparam logic [DATA_W-1:0] ONE        = 8'h01;

  typedef enum logic [1:0] {
    Q1 = 2'b00,
    Q2 = 2'b01,
    Q3 = 2'b10,
    Q4 = 2'b11
  } phase_type;

  typedef enum logic [1:0] {
    OP_OTHER    = 2'b00,
    OP_BRANCH   = 2'b01,
    OP_INC      = 2'b10,
    OP_INC_SKIP = 2'b11
  } op_type;

  // data file request toward the register file
  typedef struct packed {
    logic              rd_en;
    logic [ADDR_W-1:0] addr;
    logic              wr_en;
    logic [DATA_W-1:0] wdata;
  } file_req_type;

  typedef struct packed {
    op_type            op;
    logic              dest;
    logic [ADDR_W-1:0] addr;
    logic [LIT_W-1:0]  lit;
  } decoded_type;
endpackage

// ==== hdl/insn_decode.sv ====
/*
  combinational decode of the instruction word into operation and fields.
  assumes the word is held stable by the core across the cycle.
*/
`timescale 1ns/100ps
module insn_decode
(
  // instruction
  input  wire logic [exec_pkg::INSN_W-1:0] insn,
  // decoded result
  output      exec_pkg::decoded_type       dec
);
  import exec_pkg::*;

  always_comb
  begin
    dec.op   = OP_OTHER;
    dec.dest = insn[DEST_BIT];
    dec.addr = insn[ADDR_W-1:0];
    dec.lit  = insn[LIT_W-1:0];
    if (insn[TOP_HI:TOP_LO] == BRANCH_TOP)
    begin
      dec.op = OP_BRANCH;
    end
    else if (insn[OP_HI:OP_LO] == INC_OPC)
    begin
      dec.op = OP_INC;
    end
    else if (insn[OP_HI:OP_LO] == INC_SKIP_OPC)
    begin
      dec.op = OP_INC_SKIP;
    end
  end
endmodule

// ==== hdl/branch_and_increment_exec.sv ====
/*
  execution of the branch, increment and increment-skip instructions in four phases.
  assumes the core supplies the fetched word and data file read data on the same clock.
*/
// Functional notes
// - branch (top bits 10) loads 11-bit literal into program counter bits 10:0
// - branch copies page latch bits 4:3 into program counter bits 12:11
// - branch takes two cycles; second cycle is a no-operation
// - increment adds one, updates zero flag, destination bit picks working or file
// - increment-skip adds one, writes per destination bit, leaves flags alone
// - zero increment-skip result turns the next instruction into no-operation
// - phases: decode Q1, read Q2, process Q3, write Q4
`timescale 1ns/100ps
module branch_and_increment_exec
(
  // clock and reset
  input  wire logic                         clk,
  input  wire logic                         rst_n,
  // program memory side
  input  wire logic [exec_pkg::INSN_W-1:0]  insn,
  input  wire logic [exec_pkg::DATA_W-1:0]  page_latch_reg,
  output      logic [exec_pkg::PC_W-1:0]    program_counter,
  output      logic                         cycle_done,
  // data register file side
  input  wire logic [exec_pkg::DATA_W-1:0]  file_rdata,
  output      exec_pkg::file_req_type       file_req,
  // core state
  output      logic [exec_pkg::DATA_W-1:0]  work_reg,
  output      logic                         zero_flag,
  output      exec_pkg::phase_type          phase
);
  import exec_pkg::*;

  typedef struct packed {
    phase_type             phase;
    logic                  flush;
    decoded_type           dec;
    logic [DATA_W-1:0]     result;
    logic [PC_W-1:0]       pc;
    logic [DATA_W-1:0]     work;
    logic                  zero;
    logic                  done;
    file_req_type          req;
  } state_type;

  state_type   s_q;
  state_type   s_d;
  decoded_type dec_now;

  // phase wraps from Q4 back to Q1
  function automatic phase_type next_phase
  (
    input phase_type ph
  );
    next_phase = phase_type'(ph + 2'h1);
  endfunction

  // both increment opcodes share the read-modify-write path
  function automatic logic is_increment
  (
    input op_type op
  );
    is_increment = (op == OP_INC) || (op == OP_INC_SKIP);
  endfunction

  // zero result test for flag and skip
  function automatic logic is_zero
  (
    input logic [DATA_W-1:0] value
  );
    is_zero = (value == DATA_RESET);
  endfunction

  // next sequential program address
  function automatic logic [PC_W-1:0] step_pc
  (
    input logic [PC_W-1:0] pc
  );
    step_pc = PC_W'(pc + 13'h0001);
  endfunction

  // page bits on top of the branch literal
  function automatic logic [PC_W-1:0] branch_target
  (
    input logic [LIT_W-1:0]  lit,
    input logic [DATA_W-1:0] latch
  );
    branch_target[LIT_W-1:0]    = lit;
    branch_target[PC_W-1:LIT_W] = latch[PAGE_HI:PAGE_LO];
  endfunction

  // read strobe with address; write data otherwise held
  function automatic file_req_type read_req
  (
    input file_req_type      held,
    input logic [ADDR_W-1:0] addr
  );
    read_req       = held;
    read_req.rd_en = 1'b1;
    read_req.addr  = addr;
  endfunction

  // write strobe with address and data
  function automatic file_req_type write_req
  (
    input file_req_type      held,
    input logic [ADDR_W-1:0] addr,
    input logic [DATA_W-1:0] data
  );
    write_req       = held;
    write_req.wr_en = 1'b1;
    write_req.addr  = addr;
    write_req.wdata = data;
  endfunction

  localparam state_type STATE_RESET =
  '{
    phase:   Q1,
    flush:   1'b0,
    dec:     '0,
    result:  DATA_RESET,
    pc:      PC_RESET,
    work:    DATA_RESET,
    zero:    1'b0,
    done:    1'b0,
    req:     '0
  };

  insn_decode u_dec
  (
    .insn (insn),
    .dec  (dec_now)
  );

  always_comb
  begin
    s_d          = s_q;
    s_d.done     = 1'b0;
    s_d.req.rd_en = 1'b0;
    s_d.req.wr_en = 1'b0;
    s_d.phase    = next_phase(s_q.phase);
    unique case (s_q.phase)
      Q1:
      begin
        // decode; a flushed cycle decodes nothing
        s_d.dec = dec_now;
        if (s_q.flush)
        begin
          s_d.dec.op = OP_OTHER;
        end
      end
      Q2:
      begin
        if (is_increment(s_q.dec.op))
        begin
          s_d.req = read_req(s_d.req, s_q.dec.addr);
        end
      end
      Q3:
      begin
        if (is_increment(s_q.dec.op))
        begin
          s_d.result = DATA_W'(file_rdata + ONE);
        end
      end
      Q4:
      begin
        s_d.done  = 1'b1;
        s_d.flush = 1'b0;
        s_d.pc    = step_pc(s_q.pc);
        unique case (s_q.dec.op)
          OP_BRANCH:
          begin
            s_d.pc              = branch_target(s_q.dec.lit, page_latch_reg);
            s_d.flush           = 1'b1;
          end
          OP_INC, OP_INC_SKIP:
          begin
            if (s_q.dec.dest)
            begin
              s_d.req = write_req(s_d.req, s_q.dec.addr, s_q.result);
            end
            else
            begin
              s_d.work = s_q.result;
            end
            if (s_q.dec.op == OP_INC)
            begin
              s_d.zero = is_zero(s_q.result);
            end
            else
            begin
              s_d.flush = is_zero(s_q.result);
            end
          end
          OP_OTHER:
          begin
            s_d.flush = 1'b0;
          end
        endcase
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_q <= STATE_RESET;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign program_counter = s_q.pc;
  assign cycle_done      = s_q.done;
  assign file_req        = s_q.req;
  assign work_reg        = s_q.work;
  assign zero_flag       = s_q.zero;
  assign phase           = s_q.phase;
endmodule

// ==== verif/exec_chk.sv ====
/* port checker for the exec block.
   assumes binding to its top module. */
`timescale 1ns/100ps
module exec_chk
(
  // watched ports
  input wire logic                   clk,
  input wire logic                   rst_n,
  input wire logic [13:0]            insn,
  input wire logic [7:0]             page_latch_reg,
  input wire logic [12:0]            program_counter,
  input wire logic                   cycle_done,
  input wire logic [7:0]             file_rdata,
  input wire exec_pkg::file_req_type file_req,
  input wire logic [7:0]             work_reg,
  input wire logic                   zero_flag,
  input wire exec_pkg::phase_type    phase
);
  import exec_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_BR: assert property (phase == Q1 && insn[13:12] == BRANCH_TOP |-> ##4
    program_counter[10:0] == $past(insn[10:0], 4)) else $error("bad lit");
  AST_PG: assert property (phase == Q1 && insn[13:12] == BRANCH_TOP |-> ##4
    program_counter[12:11] == $past(page_latch_reg[4:3])) else $error("bad page");
  AST_RD: assert property (file_req.rd_en |-> phase == Q3) else $error("bad rd");
  AST_WR: assert property (file_req.wr_en |-> phase == Q1 && $past(file_req.rd_en, 2))
    else $error("bad wr");
  AST_AD: assert property (file_req.rd_en |-> file_req.addr == $past(insn[6:0], 2))
    else $error("bad addr");
  AST_IN: assert property (file_req.rd_en |-> ##2 (file_req.wr_en ? file_req.wdata :
    work_reg) == 8'($past(file_rdata, 2) + ONE)) else $error("bad sum");
  AST_ZS: assert property (file_req.rd_en && $past(insn[13:8], 2) == INC_OPC |-> ##2
    zero_flag == ($past(file_rdata, 2) == 8'hFF)) else $error("bad zero");
  AST_ZV: assert property (phase == Q1 && $past(insn[13:8], 4) != INC_OPC |->
    $stable(zero_flag)) else $error("zero moved");
  AST_DN: assert property (cycle_done == (phase == Q1 && $past(phase) == Q4))
    else $error("bad done");
endmodule
bind branch_and_increment_exec exec_chk u_exec_chk(.clk(clk), .rst_n(rst_n), .insn(insn),
  .page_latch_reg(page_latch_reg), .program_counter(program_counter),
  .cycle_done(cycle_done), .file_rdata(file_rdata), .file_req(file_req), .work_reg(work_reg),
  .zero_flag(zero_flag), .phase(phase));

// ==== verif/data_file_model.sv ====
/* behavioural 128-byte data register file.
   assumes requests from the exec block. */
`timescale 1ns/100ps
module data_file_model
(
  // request and answer
  input  wire logic                   clk,
  input  wire exec_pkg::file_req_type file_req,
  output logic [exec_pkg::DATA_W-1:0] file_rdata
);
  import exec_pkg::*;
  logic [DATA_W-1:0] mem [128];
  logic [DATA_W-1:0] last_q = 8'h5A;
  initial
    for (int i = 0; i < 128; i++)
      mem[i] = i[0] ? 8'hFF : 8'(i);
  // idle bus shows the inverse
  assign file_rdata = file_req.rd_en ? mem[file_req.addr] : ~last_q;
  always @(posedge clk)
  begin
    last_q <= file_rdata;
    if (file_req.wr_en)
      mem[file_req.addr] <= file_req.wdata;
  end
endmodule

// ==== verif/branch_and_increment_exec_tb.sv ====
/* self-checking bench for the exec block.
   assumes the data file model beside it. */
`timescale 1ns/100ps
module branch_and_increment_exec_tb;
  import exec_pkg::*;
  logic              clk = 0;
  logic              rst_n = 0;
  logic [INSN_W-1:0] insn = '0;
  logic [DATA_W-1:0] page = 8'hF0;
  logic [DATA_W-1:0] rdata, work;
  logic [PC_W-1:0]   pc;
  logic              done, zf;
  phase_type         ph;
  file_req_type      req;
  int                mismatches = 0, total_checks = 0, cyc = 0;
  always #10 clk = ~clk;
  branch_and_increment_exec u_branch_and_increment_exec(.clk(clk), .rst_n(rst_n),
    .insn(insn), .page_latch_reg(page), .program_counter(pc), .cycle_done(done),
    .file_rdata(rdata), .file_req(req), .work_reg(work), .zero_flag(zf), .phase(ph));
  data_file_model u_data_file_model(.clk(clk), .file_req(req), .file_rdata(rdata));
  task close_out;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task chk(string n, logic [15:0] e, logic [15:0] s);
    total_checks++;
    if (s !== e)
    begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task go(logic [INSN_W-1:0] i);
    do @(posedge clk); while (ph !== Q4);
    insn <= i;
  endtask
  task t_branch;
    go(14'h2DA5);
    go({INC_OPC, 1'b1, 7'd2});
    #1 chk("pc", 16'h15A5, pc);
    go('0);
    #1 chk("pc", 16'h15A6, pc);
    chk("m2", 16'h02, u_data_file_model.mem[2]);
  endtask
  task t_inc;
    go({INC_OPC, 1'b1, 7'd1});
    go({INC_OPC, 1'b0, 7'd2});
    #1 chk("z", 16'h1, zf);
    go('0);
    #1 chk("m1", 16'h00, u_data_file_model.mem[1]);
    chk("w", 16'h03, work);
    chk("z", 16'h0, zf);
    chk("m2", 16'h02, u_data_file_model.mem[2]);
  endtask
  task t_skip;
    go({INC_SKIP_OPC, 1'b1, 7'd3});
    go({INC_OPC, 1'b1, 7'd2});
    #1 chk("z", 16'h0, zf);
    go({INC_SKIP_OPC, 1'b0, 7'd0});
    go({INC_OPC, 1'b1, 7'd4});
    go('0);
    go('0);
    #1 chk("m3", 16'h00, u_data_file_model.mem[3]);
    chk("z", 16'h0, zf);
    chk("m2", 16'h02, u_data_file_model.mem[2]);
    chk("w", 16'h01, work);
    chk("m4", 16'h05, u_data_file_model.mem[4]);
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc > 400)
    begin
      mismatches++;
      close_out;
    end
  end
  initial
  begin
    repeat (4) @(posedge clk);
    rst_n <= 1;
    t_branch;
    t_inc;
    t_skip;
    close_out;
  end
endmodule
